// *** hdl/sim_defines.svh ***
`ifndef SIM_DEFINES_SVH
`define SIM_DEFINES_SVH
// register byte addresses
`define SIM_ADDR_CTRL 12'h000
`define SIM_ADDR_STATE 12'h004
`define SIM_ADDR_IRQ_STAT 12'h008
`define SIM_ADDR_IRQ_MASK 12'h00c
// control register fields
`define SIM_CTRL_RESET_BIT 0
`define SIM_CTRL_RUN_BIT 1
// interrupt event bit positions
`define SIM_EV_DOOR_CRIT 0
`define SIM_EV_HALT_CRIT 1
`define SIM_EV_DOOR_OPEN 2
`define SIM_EV_HALT 3
`define SIM_EV_CLEARED 4
`define SIM_EV_WIDTH 5
// reset values
`define SIM_IRQ_MASK_RST 5'h00
`define SIM_RUN_RST 1'b0
// status after reset: everything but critical error raised
`define SIM_STATUS_RST 6'h3e
// timing
`define SIM_CLK_HZ 10000000
`define SIM_MISMATCH_MS 2000
`define SIM_MISMATCH_CYC ((`SIM_CLK_HZ / 1000) * `SIM_MISMATCH_MS)
`define SIM_CNT_W 25
`endif

// *** hdl/sim_pkg.sv ***
package sim_pkg;
  // axi4-lite request and answer bundles
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } sim_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sim_axi_rsp_t;
  // redundant pair state
  typedef enum logic [1:0] {
    SIM_PAIR_AGREE = 2'b00,
    SIM_PAIR_DIFFER = 2'b01,
    SIM_PAIR_FAULT = 2'b11
  } sim_pair_t;
  // machine outputs
  typedef struct packed {
    logic motionProhibit;
    logic programPause;
    logic safetyActive;
    logic haltStatus;
    logic haltLed;
    logic critError;
  } sim_status_t;
endpackage : sim_pkg

// *** hdl/sim_interlock.sv ***
`timescale 1ns/100ps
`include "sim_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - door pair differing two seconds or more raises critical error
// - halt pair differing two seconds or more raises critical error
// - open door pauses program and prohibits manipulator power
// - door-open and teach-mode conditions are latched when they occur
// - door and teach latches stay set while hold-clear input is open
// - closing hold-clear clears door and teach latches whose causes are gone
// - teach released with door open keeps power prohibited
// - safety-active shown while door latched, cleared after door and release close
// - active halt lights indicator and reports halt status
// - halt state held after release until reset command
module sim_interlock (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // door contacts, high means closed
  input wire logic door_channel_a_pos,
  input wire logic door_channel_b_pos,
  // halt loop contacts, high means loop closed (not pressed)
  input wire logic halt_loop_a_pos,
  input wire logic halt_loop_b_pos,
  // hold-clear input, high means closed
  input wire logic hold_clear_input_pos,
  // pendant mode selector, high while teach mode selected
  input wire logic teachMode,
  // register bus
  input wire sim_pkg::sim_axi_req_t axiReq,
  output sim_pkg::sim_axi_rsp_t axiRsp,
  // safety outputs
  output sim_pkg::sim_status_t status,
  output logic irq
);
  import sim_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // redundant pair watchdogs
  localparam int unsigned MisCyc = `SIM_MISMATCH_CYC;
  logic [`SIM_CNT_W-1:0] doorCnt_ff, haltCnt_ff;
  logic [`SIM_CNT_W-1:0] nxt_doorCnt, nxt_haltCnt;
  logic doorCrit_ff, haltCrit_ff;
  wire doorDiffer = door_channel_a_pos ^ door_channel_b_pos;
  wire haltDiffer = halt_loop_a_pos ^ halt_loop_b_pos;
  wire doorExpire = doorDiffer && (doorCnt_ff == `SIM_CNT_W'(MisCyc - 1));
  wire haltExpire = haltDiffer && (haltCnt_ff == `SIM_CNT_W'(MisCyc - 1));
  // counters saturate; agreement restarts from zero
  assign nxt_doorCnt = !doorDiffer ? '0 : (doorExpire ? doorCnt_ff : doorCnt_ff + 1'b1);
  assign nxt_haltCnt = !haltDiffer ? '0 : (haltExpire ? haltCnt_ff : haltCnt_ff + 1'b1);
  wire doorPairOpen = !door_channel_a_pos || !door_channel_b_pos; // either open counts as open
  wire haltActive = !halt_loop_a_pos || !halt_loop_b_pos;

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic resetCmd;
  logic runReq_ff;
  logic [`SIM_EV_WIDTH-1:0] irqStat_ff, irqMask_ff, nxt_irqStat, events;
  logic doorLatch_ff, teachLatch_ff, haltLatch_ff;
  logic nxt_doorLatch, nxt_teachLatch, nxt_haltLatch;

  // watchdog flops
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      doorCnt_ff <= '0;
      haltCnt_ff <= '0;
      doorCrit_ff <= 1'b0;
      haltCrit_ff <= 1'b0;
    end
    else
    begin
      doorCnt_ff <= nxt_doorCnt;
      haltCnt_ff <= nxt_haltCnt;
      doorCrit_ff <= doorExpire || (doorCrit_ff && !resetCmd);
      haltCrit_ff <= haltExpire || (haltCrit_ff && !resetCmd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // condition latches; set wins over any clear
  assign nxt_doorLatch = doorPairOpen || (doorLatch_ff && !hold_clear_input_pos);
  assign nxt_teachLatch = teachMode || (teachLatch_ff && !hold_clear_input_pos);
  // halt held after release until software reset command
  assign nxt_haltLatch = haltActive || (haltLatch_ff && !resetCmd);

  // door and halt latches start set, teach latch clear, so a door open at power-up shows at once
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      doorLatch_ff <= 1'b1;
      teachLatch_ff <= 1'b0;
      haltLatch_ff <= 1'b1;
    end
    else
    begin
      doorLatch_ff <= nxt_doorLatch;
      teachLatch_ff <= nxt_teachLatch;
      haltLatch_ff <= nxt_haltLatch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  wire critAny = doorCrit_ff || haltCrit_ff;
  sim_status_t nxt_status;
  assign nxt_status.motionProhibit = nxt_doorLatch || nxt_haltLatch || critAny;
  assign nxt_status.programPause = nxt_doorLatch || !runReq_ff;
  assign nxt_status.safetyActive = nxt_doorLatch;
  assign nxt_status.haltStatus = nxt_haltLatch;
  assign nxt_status.haltLed = nxt_haltLatch || critAny;
  assign nxt_status.critError = critAny;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      status <= `SIM_STATUS_RST;
    else
      status <= nxt_status;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events: rising edges of both critical flags and of the door and halt latches (none for teach), plus the falling edge of the door latch
  logic doorCritD_ff, haltCritD_ff, doorLatchD_ff, haltLatchD_ff;
  assign events[`SIM_EV_DOOR_CRIT] = doorCrit_ff && !doorCritD_ff;
  assign events[`SIM_EV_HALT_CRIT] = haltCrit_ff && !haltCritD_ff;
  assign events[`SIM_EV_DOOR_OPEN] = doorLatch_ff && !doorLatchD_ff;
  assign events[`SIM_EV_HALT] = haltLatch_ff && !haltLatchD_ff;
  assign events[`SIM_EV_CLEARED] = !doorLatch_ff && doorLatchD_ff;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read outstanding
  logic awHeld_ff, wHeld_ff, bValid_ff, rValid_ff;
  logic [11:0] awAddr_ff, arAddr;
  logic [31:0] wData_ff, rData_ff;
  logic [3:0] wStrb_ff;
  logic [1:0] bResp_ff, rResp_ff;
  wire awTake = axiReq.awvalid && !awHeld_ff && !bValid_ff;
  wire wTake = axiReq.wvalid && !wHeld_ff && !bValid_ff;
  wire wrFire = awHeld_ff && wHeld_ff;
  wire arTake = axiReq.arvalid && !rValid_ff;
  // low address bits ignored, same as on the write side
  assign arAddr = {axiReq.araddr[11:2], 2'b00};
  wire wrCtrl = wrFire && (awAddr_ff == `SIM_ADDR_CTRL) && wStrb_ff[0];
  wire wrStat = wrFire && (awAddr_ff == `SIM_ADDR_IRQ_STAT) && wStrb_ff[0];
  wire wrMask = wrFire && (awAddr_ff == `SIM_ADDR_IRQ_MASK) && wStrb_ff[0];
  wire wrOk = (awAddr_ff == `SIM_ADDR_CTRL) || (awAddr_ff == `SIM_ADDR_STATE)
    || (awAddr_ff == `SIM_ADDR_IRQ_STAT) || (awAddr_ff == `SIM_ADDR_IRQ_MASK);
  assign resetCmd = wrCtrl && wData_ff[`SIM_CTRL_RESET_BIT];
  // write-one-to-clear; a new event in the same cycle survives
  assign nxt_irqStat = events | (irqStat_ff & ~(wrStat ? wData_ff[`SIM_EV_WIDTH-1:0] : '0));

  // read mux, unmapped reads answer slverr with zero
  logic [31:0] rdMux;
  logic rdOk;
  wire [31:0] stateWord = {23'h0, teachLatch_ff, nxt_status.motionProhibit, haltLatch_ff,
    doorLatch_ff, haltCrit_ff, doorCrit_ff, doorPairOpen, haltActive, teachMode};
  always_comb
  begin
    rdOk = 1'b1;
    if (arAddr == `SIM_ADDR_CTRL)
      rdMux = {30'h0, runReq_ff, 1'b0};
    else if (arAddr == `SIM_ADDR_STATE)
      rdMux = stateWord;
    else if (arAddr == `SIM_ADDR_IRQ_STAT)
      rdMux = {27'h0, irqStat_ff};
    else if (arAddr == `SIM_ADDR_IRQ_MASK)
      rdMux = {27'h0, irqMask_ff};
    else
    begin
      rdMux = 32'h0;
      rdOk = 1'b0;
    end
  end

  // write channel capture and response
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      bValid_ff <= 1'b0;
      awAddr_ff <= 12'h000;
      wData_ff <= 32'h0;
      wStrb_ff <= 4'h0;
      bResp_ff <= 2'h0;
    end
    else
    begin
      if (awTake)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= {axiReq.awaddr[11:2], 2'b00};
      end
      if (wTake)
      begin
        wHeld_ff <= 1'b1;
        wData_ff <= axiReq.wdata;
        wStrb_ff <= axiReq.wstrb;
      end
      if (wrFire)
      begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff <= wrOk ? 2'b00 : 2'b10;
      end
      else if (bValid_ff && axiReq.bready)
        bValid_ff <= 1'b0;
    end
  end

  // read response
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rValid_ff <= 1'b0;
      rData_ff <= 32'h0;
      rResp_ff <= 2'h0;
    end
    else if (arTake)
    begin
      rValid_ff <= 1'b1;
      rData_ff <= rdMux;
      rResp_ff <= rdOk ? 2'b00 : 2'b10;
    end
    else if (rValid_ff && axiReq.rready)
      rValid_ff <= 1'b0;
  end

  // software registers and interrupt
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      runReq_ff <= `SIM_RUN_RST;
      irqMask_ff <= `SIM_IRQ_MASK_RST;
      irqStat_ff <= '0;
      irq <= 1'b0;
      doorCritD_ff <= 1'b0;
      haltCritD_ff <= 1'b0;
      doorLatchD_ff <= 1'b1;
      haltLatchD_ff <= 1'b1;
    end
    else
    begin
      if (wrCtrl)
        runReq_ff <= wData_ff[`SIM_CTRL_RUN_BIT];
      if (wrMask)
        irqMask_ff <= wData_ff[`SIM_EV_WIDTH-1:0];
      irqStat_ff <= nxt_irqStat;
      irq <= |(nxt_irqStat & (wrMask ? wData_ff[`SIM_EV_WIDTH-1:0] : irqMask_ff));
      doorCritD_ff <= doorCrit_ff;
      haltCritD_ff <= haltCrit_ff;
      doorLatchD_ff <= doorLatch_ff;
      haltLatchD_ff <= haltLatch_ff;
    end
  end

  assign axiRsp = '{awready: !awHeld_ff && !bValid_ff, wready: !wHeld_ff && !bValid_ff,
    bvalid: bValid_ff, bresp: bResp_ff, arready: !rValid_ff, rvalid: rValid_ff,
    rdata: rData_ff, rresp: rResp_ff};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence doorHeldOpen;
    doorPairOpen ##1 1'b1;
  endsequence
  door_pause_prohibit_a: assert property (@(posedge clock) disable iff (sys_rst)
    doorHeldOpen |-> status.motionProhibit && status.programPause)
    else $error("open door did not prohibit motion");
  door_crit_raise_a: assert property (@(posedge clock) disable iff (sys_rst)
    doorExpire |=> doorCrit_ff)
    else $error("door mismatch did not raise critical error");
  halt_crit_raise_a: assert property (@(posedge clock) disable iff (sys_rst)
    haltExpire |=> haltCrit_ff)
    else $error("halt mismatch did not raise critical error");
  timer_restart_a: assert property (@(posedge clock) disable iff (sys_rst)
    !doorDiffer |=> doorCnt_ff == '0)
    else $error("door timer not restarted on agreement");
  latch_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    doorLatch_ff && !hold_clear_input_pos |=> doorLatch_ff)
    else $error("door latch dropped while release open");
  latch_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    hold_clear_input_pos && !doorPairOpen && !teachMode |=> !doorLatch_ff && !teachLatch_ff)
    else $error("latch not cleared on release");
  teach_open_prohibit_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(teachLatch_ff) && doorPairOpen |=> status.motionProhibit)
    else $error("power allowed with door latched");
  halt_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    haltLatch_ff && !haltActive && !resetCmd |=> haltLatch_ff && status.haltLed)
    else $error("halt state dropped without reset");
  halt_report_a: assert property (@(posedge clock) disable iff (sys_rst)
    haltActive |=> status.haltStatus && status.haltLed)
    else $error("active halt not reported");
  safety_shown_a: assert property (@(posedge clock) disable iff (sys_rst)
    doorLatch_ff |-> ##1 status.safetyActive || $past(hold_clear_input_pos))
    else $error("safety indication missing");
endmodule : sim_interlock

// *** verification/sim_contact_model.sv ***
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// far-side switch contacts; each pair comes from one switch with two contact sets
module sim_contact_model (
  // clock
  input wire logic clock,
  // commands from the bench
  input wire logic doorShut,
  input wire logic haltShut,
  input wire logic releaseShut,
  input wire logic teachSel,
  input wire logic skewDoor,
  // contact outputs, all closed-high
  output logic door_channel_a_pos = 1'b0,
  output logic door_channel_b_pos = 1'b0,
  output logic halt_loop_a_pos = 1'b0,
  output logic halt_loop_b_pos = 1'b0,
  output logic hold_clear_input_pos = 1'b0,
  output logic teachMode = 1'b0
);
  // pairs move together; a skew is only ever a commanded fault
  always @(posedge clock)
  begin
    door_channel_a_pos <= doorShut;
    door_channel_b_pos <= skewDoor ? !doorShut : doorShut;
    halt_loop_a_pos <= haltShut;
    halt_loop_b_pos <= haltShut;
    hold_clear_input_pos <= releaseShut;
    teachMode <= teachSel;
  end
endmodule : sim_contact_model

// *** verification/sim_interlock_tb.sv ***
`timescale 1ns/100ps
`include "sim_defines.svh"
module sim_interlock_tb;
  import sim_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic doorShut, haltShut, releaseShut, teachSel, skewDoor;
  logic dA, dB, hA, hB, rel, teach, irq;
  logic [31:0] rd;
  logic [1:0] rr;
  sim_axi_req_t req;
  sim_axi_rsp_t rsp;
  sim_status_t status;
  // outputs captured mid-cycle, away from the launching edge
  sim_status_t statusSnap;
  logic irqSnap;
  int errors = 0;
  int compares = 0;
  int doorM, haltM, runM;
  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  always #50 clock = !clock;
  sim_contact_model PART (.clock(clock), .doorShut(doorShut), .haltShut(haltShut),
    .releaseShut(releaseShut), .teachSel(teachSel), .skewDoor(skewDoor),
    .door_channel_a_pos(dA), .door_channel_b_pos(dB), .halt_loop_a_pos(hA),
    .halt_loop_b_pos(hB), .hold_clear_input_pos(rel), .teachMode(teach));
  sim_interlock DUT (.clock(clock), .sys_rst(sys_rst), .door_channel_a_pos(dA),
    .door_channel_b_pos(dB), .halt_loop_a_pos(hA), .halt_loop_b_pos(hB),
    .hold_clear_input_pos(rel), .teachMode(teach), .axiReq(req), .axiRsp(rsp),
    .status(status), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // expected outputs from the latch model: prohibit follows either latch
  function automatic logic [31:0] exp_status();
    logic p;
    p = (doorM != 0) || (haltM != 0);
    return {26'h0, p, (doorM != 0) | (runM == 0), doorM != 0, haltM != 0, haltM != 0, 1'b0};
  endfunction : exp_status
  task automatic cmp_status();
    check(32'(statusSnap), exp_status(), "status");
  endtask : cmp_status
  // status lags the contacts by the partner edge plus one; snapshot at the falling edge
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
    statusSnap = status;
    irqSnap = irq;
    @(posedge clock);
  endtask : settle
  // bus master tasks; each is entered right after a rising edge
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic awHs, wHs, bHs;
    logic [1:0] resp;
    n = 0;
    bHs = 1'b0;
    resp = 2'b00;
    // one idle edge keeps back-to-back calls from driving a signal twice at once
    @(posedge clock);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    // handshakes judged on settled values, acted on right after the edge
    do
    begin
      @(negedge clock);
      awHs = req.awvalid && rsp.awready;
      wHs = req.wvalid && rsp.wready;
      bHs = (rsp.bvalid === 1'b1);
      resp = rsp.bresp;
      @(posedge clock);
      if (awHs) req.awvalid <= 1'b0;
      if (wHs) req.wvalid <= 1'b0;
      n++;
    end while (!bHs && n < 200);
    req.bready <= 1'b0;
    if (n >= 200)
    begin
      check(32'h1, 32'h0, "write hang");
      test_done();
    end
    check({30'h0, resp}, 32'h0, "write response");
  endtask : axi_write
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic arHs, rHs;
    n = 0;
    rHs = 1'b0;
    d = 32'h0;
    r = 2'b00;
    @(posedge clock);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    // data taken from the cycle in which rvalid stands
    do
    begin
      @(negedge clock);
      arHs = req.arvalid && rsp.arready;
      rHs = (rsp.rvalid === 1'b1);
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge clock);
      if (arHs) req.arvalid <= 1'b0;
      n++;
    end while (!rHs && n < 200);
    req.rready <= 1'b0;
    if (n >= 200)
    begin
      check(32'h1, 32'h0, "read hang");
      test_done();
    end
  endtask : axi_read
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h6f46));
    req = '0;
    {doorShut, haltShut, releaseShut, teachSel, skewDoor} = 5'h00;
    doorM = 1;
    haltM = 1;
    runM = 0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    cmp_status();
    check({31'h0, irqSnap}, 32'h0, "irq after reset");
    // door closed before release, then the reset command clears halt
    doorShut <= 1'b1;
    haltShut <= 1'b1;
    settle();
    releaseShut <= 1'b1;
    doorM = 0;
    settle();
    cmp_status();
    axi_write(`SIM_ADDR_CTRL, 32'h3);
    haltM = 0;
    runM = 1;
    settle();
    cmp_status();
    // door latch holds until release closes
    releaseShut <= 1'b0;
    doorShut <= 1'b0;
    doorM = 1;
    settle();
    cmp_status();
    doorShut <= 1'b1;
    settle();
    cmp_status();
    releaseShut <= 1'b1;
    doorM = 0;
    settle();
    cmp_status();
    // teach latch, then released with door open
    releaseShut <= 1'b0;
    teachSel <= 1'b1;
    settle();
    teachSel <= 1'b0;
    settle();
    axi_read(`SIM_ADDR_STATE, rd, rr);
    check({31'h0, rd[8]}, 32'h1, "teach latch");
    doorShut <= 1'b0;
    doorM = 1;
    releaseShut <= 1'b1;
    settle();
    axi_read(`SIM_ADDR_STATE, rd, rr);
    check({30'h0, rd[8], rd[5]}, 32'h1, "latches");
    cmp_status();
    doorShut <= 1'b1;
    doorM = 0;
    settle();
    cmp_status();
    // halt is held after the loop closes until the reset command
    haltShut <= 1'b0;
    haltM = 1;
    settle();
    cmp_status();
    haltShut <= 1'b1;
    settle();
    cmp_status();
    axi_write(`SIM_ADDR_CTRL, 32'h3);
    haltM = 0;
    settle();
    cmp_status();
    // short disagreements of random length never reach the limit
    repeat (4)
    begin
      skewDoor <= 1'b1;
      repeat (1 + $urandom % 40) @(posedge clock);
      skewDoor <= 1'b0;
      settle();
      cmp_status();
    end
    axi_read(`SIM_ADDR_STATE, rd, rr);
    check({31'h0, rd[3]}, 32'h0, "door crit");
    // interrupt raised, masked, cleared
    axi_write(`SIM_ADDR_IRQ_STAT, 32'h1f);
    axi_write(`SIM_ADDR_IRQ_MASK, 32'h4);
    settle();
    check({31'h0, irqSnap}, 32'h0, "irq idle");
    doorShut <= 1'b0;
    settle();
    check({31'h0, irqSnap}, 32'h1, "irq raised");
    axi_write(`SIM_ADDR_IRQ_MASK, 32'h0);
    settle();
    check({31'h0, irqSnap}, 32'h0, "irq masked");
    doorShut <= 1'b1;
    settle();
    axi_write(`SIM_ADDR_IRQ_STAT, 32'h1f);
    axi_write(`SIM_ADDR_IRQ_MASK, 32'h4);
    settle();
    check({31'h0, irqSnap}, 32'h0, "irq cleared");
    // unmapped address is refused with zero data
    axi_read(12'h010, rd, rr);
    check({rr, rd[29:0]}, 32'h80000000, "unmapped read");
    test_done();
  end
endmodule : sim_interlock_tb
